// ### rtl/epcs_pkg.sv
// Purpose: constants for the engine protection and crank sequencer
// Assumes: 25 MHz pclk, APB register access
// Notes: setpoints are 16-bit; levels in raw sensor units, delays in seconds, throttle pulses in microseconds
package epcs_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES_DEF = CLK_HZ * SEC_S;
    localparam int RATE_MS = 100;
    localparam int RATE_CYCLES_DEF = CLK_HZ / 1000 * RATE_MS;
    localparam int MINUTE_S = 60;
    localparam int PULSE_UNIT_US = 1;
    localparam int US_CYCLES = CLK_HZ / 1_000_000 * PULSE_UNIT_US;
    localparam logic [15:0] BATT_HYST = 16'h0002;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_RPM = 8'h08;
    localparam logic [7:0] A_CMD = 8'h0C;
    localparam logic [7:0] A_LOAD = 8'h10;
    localparam logic [7:0] A_SP = 8'h40;
    localparam int C_RUN = 0;
    localparam int C_AUTO = 1;
    localparam int C_MECH = 2;
    localparam int C_CLR = 3;
    localparam logic [2:0] CTRL_RST = 3'h6;
    localparam logic [15:0] LOAD_RST = 16'h0640;
    localparam int S_OIL = 3;
    localparam int S_TEMP = 4;
    localparam int S_FUEL = 5;
    localparam int S_FAIL = 6;
    localparam int S_FUEL_AL = 7;
    localparam int S_BATT_AL = 8;
    localparam int S_TRIES = 16;
    // ----------------------------------------
    // setpoint table
    // ----------------------------------------
    localparam int SP_N = 24;
    localparam int SP_OIL_LO = 0;
    localparam int SP_OIL_HI = 1;
    localparam int SP_REF_LO = 2;
    localparam int SP_REF_HI = 3;
    localparam int SP_TEMP = 4;
    localparam int SP_FUEL_AL = 5;
    localparam int SP_FUEL_SD = 6;
    localparam int SP_BATT = 7;
    localparam int SP_WARM = 8;
    localparam int SP_COOL = 9;
    localparam int SP_CRANK = 10;
    localparam int SP_REST = 11;
    localparam int SP_RECRANK = 12;
    localparam int SP_CRANK_STOP = 13;
    localparam int SP_TRIES = 14;
    localparam int SP_WARM_SPD = 15;
    localparam int SP_COOL_SPD = 16;
    localparam int SP_FLOOR = 17;
    localparam int SP_CEIL = 18;
    localparam int SP_RISE = 19;
    localparam int SP_FALL = 20;
    localparam int SP_PULSE = 21;
    localparam int SP_LOCK = 22;
    localparam int SP_PPR = 23;
    localparam logic [15:0] SP_RST [SP_N] = '{
        16'h000F, 16'h001E, 16'h0258, 16'h0640, 16'h00DC, 16'h0000,
        16'h0000, 16'h0064, 16'h00B4, 16'h00B4, 16'h000A, 16'h000A,
        16'h000A, 16'h012C, 16'h0006, 16'h0258, 16'h0258, 16'h02EE,
        16'h0640, 16'h000A, 16'h000A, 16'h20D0, 16'h001E, 16'h0078};
    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CRANK = 3'h1,
        ST_REST = 3'h3,
        ST_WAIT = 3'h2,
        ST_WARM = 3'h6,
        ST_LOAD = 3'h7,
        ST_COOL = 3'h5,
        ST_SHUT = 3'h4
    } epcs_state_t;
endpackage

// ### rtl/epcs_top.sv
// Purpose: engine protection, crank/rest sequencing, speed setpoint
// Assumes: sensor inputs synchronous to pclk, zero-wait APB slave
// Notes: sequencer delays and the oil lockout count whole seconds of the SEC_CYCLES tick; throttle pulses count microseconds
`timescale 1ns/1ns
module epcs_top #(
    parameter int SEC_CYCLES = epcs_pkg::SEC_CYCLES_DEF,
    parameter int RATE_CYCLES = epcs_pkg::RATE_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] oil_press,
    input wire logic [15:0] coolant_temp,
    input wire logic [15:0] fuel_level,
    input wire logic [15:0] battery_volts,
    input wire logic speed_pulse,
    output logic starter,
    output logic fuel_run,
    output logic clutch,
    output logic throttle_up,
    output logic throttle_down,
    output logic shutdown,
    output logic alarm
);
    localparam int MIN_CYC = SEC_CYCLES * epcs_pkg::MINUTE_S;

    typedef struct packed {
        logic [2:0] ctrl;
        logic [15:0] load;
        logic [epcs_pkg::SP_N-1:0][15:0] sp;
        epcs_pkg::epcs_state_t st;
        logic [15:0] tmr;
        logic [15:0] lock;
        logic [7:0] tries;
        logic [31:0] sec_cnt;
        logic [31:0] rate_cnt;
        logic [31:0] acc;
        logic [15:0] pcnt;
        logic [15:0] rpm;
        logic pin_q;
        logic [15:0] cmd;
        logic [15:0] thr_cnt;
        logic [7:0] us_cnt;
        logic up;
        logic dn;
        logic oil_sd;
        logic temp_sd;
        logic fuel_sd;
        logic fail_sd;
        logic fuel_al;
        logic batt_al;
    } epcs_regs_t;

    epcs_regs_t s_r;
    epcs_regs_t s_nxt;

    logic wr;
    logic clr;
    logic sp_hit;
    logic [4:0] sp_idx;
    logic [7:0] sp_off;
    logic sec_tick;
    logic rate_tick;
    logic us_tick;
    logic edge_seen;
    logic running;
    logic eng_on;
    logic lock_done;
    logic any_sd;
    logic [15:0] oil_lvl;
    logic oil_trip;
    logic temp_trip;
    logic fuel_trip;
    logic fail_trip;
    logic [15:0] tgt;
    logic [15:0] diff;
    logic want_up;
    logic want_dn;
    logic [31:0] acc_sum;

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign sp_off = paddr - epcs_pkg::A_SP;
    assign sp_hit = (paddr >= epcs_pkg::A_SP) && (paddr[1:0] == 2'h0)
        && (sp_off[7:2] < 6'(epcs_pkg::SP_N));
    assign sp_idx = sp_off[6:2];
    assign clr = wr && (paddr == epcs_pkg::A_CTRL)
        && pwdata[epcs_pkg::C_CLR];

    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        if (sp_hit) begin
            prdata = {16'h0, s_r.sp[sp_idx]};
        end else begin
            case (paddr)
                epcs_pkg::A_CTRL: prdata = {29'h0, s_r.ctrl};
                epcs_pkg::A_STAT: begin
                    prdata[2:0] = s_r.st;
                    prdata[epcs_pkg::S_OIL] = s_r.oil_sd;
                    prdata[epcs_pkg::S_TEMP] = s_r.temp_sd;
                    prdata[epcs_pkg::S_FUEL] = s_r.fuel_sd;
                    prdata[epcs_pkg::S_FAIL] = s_r.fail_sd;
                    prdata[epcs_pkg::S_FUEL_AL] = s_r.fuel_al;
                    prdata[epcs_pkg::S_BATT_AL] = s_r.batt_al;
                    prdata[epcs_pkg::S_TRIES +: 8] = s_r.tries;
                end
                epcs_pkg::A_RPM: prdata = {16'h0, s_r.rpm};
                epcs_pkg::A_CMD: prdata = {16'h0, s_r.cmd};
                epcs_pkg::A_LOAD: prdata = {16'h0, s_r.load};
                default: pslverr = psel & penable;
            endcase
        end
    end

    // ----------------------------------------
    // protection
    // ----------------------------------------
    assign running = s_r.rpm >= s_r.sp[epcs_pkg::SP_CRANK_STOP];
    assign eng_on = (s_r.st == epcs_pkg::ST_WARM)
        || (s_r.st == epcs_pkg::ST_LOAD)
        || (s_r.st == epcs_pkg::ST_COOL);
    assign lock_done = s_r.lock == 16'h0;
    // below the full reference the idle level applies
    assign oil_lvl = (s_r.rpm >= s_r.sp[epcs_pkg::SP_REF_HI])
        ? s_r.sp[epcs_pkg::SP_OIL_HI]
        : s_r.sp[epcs_pkg::SP_OIL_LO];
    // no oil check while spinning up below idle
    assign oil_trip = eng_on && lock_done
        && (s_r.rpm >= s_r.sp[epcs_pkg::SP_REF_LO])
        && (oil_press <= oil_lvl);
    assign temp_trip = coolant_temp > s_r.sp[epcs_pkg::SP_TEMP];
    assign fuel_trip = (s_r.sp[epcs_pkg::SP_FUEL_SD] != 16'h0)
        && (fuel_level <= s_r.sp[epcs_pkg::SP_FUEL_SD]);
    assign any_sd = s_r.oil_sd | s_r.temp_sd | s_r.fuel_sd | s_r.fail_sd;
    assign acc_sum = s_r.acc + {16'h0, s_r.sp[epcs_pkg::SP_PPR]};
    assign edge_seen = speed_pulse & ~s_r.pin_q;
    assign sec_tick = s_r.sec_cnt == 32'(SEC_CYCLES - 1);
    assign rate_tick = s_r.rate_cnt == 32'(RATE_CYCLES - 1);
    assign us_tick = s_r.us_cnt == 8'(epcs_pkg::US_CYCLES - 1);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        fail_trip = 1'b0;
        tgt = 16'h0;
        diff = 16'h0;
        want_up = 1'b0;
        want_dn = 1'b0;
        s_nxt.pin_q = speed_pulse;
        s_nxt.sec_cnt = sec_tick ? 32'h0 : s_r.sec_cnt + 32'h1;
        s_nxt.rate_cnt = rate_tick ? 32'h0 : s_r.rate_cnt + 32'h1;
        s_nxt.us_cnt = us_tick ? 8'h0 : s_r.us_cnt + 8'h1;
        // window of 60/ppr seconds makes the count read in rpm
        if (acc_sum >= 32'(MIN_CYC)) begin
            s_nxt.acc = acc_sum - 32'(MIN_CYC);
            s_nxt.rpm = s_r.pcnt;
            s_nxt.pcnt = {15'h0, edge_seen};
        end else begin
            s_nxt.acc = acc_sum;
            s_nxt.pcnt = s_r.pcnt + {15'h0, edge_seen};
        end
        if (wr && paddr == epcs_pkg::A_CTRL) begin
            s_nxt.ctrl = pwdata[2:0];
        end
        if (wr && paddr == epcs_pkg::A_LOAD) begin
            s_nxt.load = pwdata[15:0];
        end
        if (wr && sp_hit) begin
            s_nxt.sp[sp_idx] = pwdata[15:0];
        end
        if (sec_tick && s_r.tmr != 16'h0) begin
            s_nxt.tmr = s_r.tmr - 16'h1;
        end
        if (sec_tick && !lock_done) begin
            s_nxt.lock = s_r.lock - 16'h1;
        end
        case (s_r.st)
            epcs_pkg::ST_IDLE: begin
                if (s_r.ctrl[epcs_pkg::C_RUN] && !any_sd) begin
                    s_nxt.st = epcs_pkg::ST_CRANK;
                    s_nxt.tries = 8'h1;
                    s_nxt.tmr = s_r.sp[epcs_pkg::SP_CRANK];
                end
            end
            epcs_pkg::ST_CRANK: begin
                if (running) begin
                    s_nxt.st = epcs_pkg::ST_WARM;
                    s_nxt.tmr = s_r.sp[epcs_pkg::SP_WARM];
                    s_nxt.lock = s_r.sp[epcs_pkg::SP_LOCK];
                end else if (s_r.tmr == 16'h0) begin
                    if (s_r.tries >= s_r.sp[epcs_pkg::SP_TRIES][7:0]) begin
                        fail_trip = 1'b1;
                    end else begin
                        s_nxt.st = epcs_pkg::ST_REST;
                        s_nxt.tmr = s_r.sp[epcs_pkg::SP_REST];
                    end
                end
            end
            epcs_pkg::ST_REST,
            epcs_pkg::ST_WAIT: begin
                if (s_r.tmr == 16'h0) begin
                    s_nxt.st = epcs_pkg::ST_CRANK;
                    s_nxt.tries = s_r.tries + 8'h1;
                    s_nxt.tmr = s_r.sp[epcs_pkg::SP_CRANK];
                end
            end
            epcs_pkg::ST_WARM: begin
                if (!running && !lock_done) begin
                    if (s_r.tries >= s_r.sp[epcs_pkg::SP_TRIES][7:0]) begin
                        fail_trip = 1'b1;
                    end else begin
                        s_nxt.st = epcs_pkg::ST_WAIT;
                        s_nxt.tmr = s_r.sp[epcs_pkg::SP_RECRANK];
                    end
                end else if (!s_r.ctrl[epcs_pkg::C_RUN]) begin
                    s_nxt.st = epcs_pkg::ST_COOL;
                    s_nxt.tmr = s_r.sp[epcs_pkg::SP_COOL];
                end else if (s_r.tmr == 16'h0) begin
                    s_nxt.st = epcs_pkg::ST_LOAD;
                end
            end
            epcs_pkg::ST_LOAD: begin
                if (!s_r.ctrl[epcs_pkg::C_RUN]) begin
                    s_nxt.st = epcs_pkg::ST_COOL;
                    s_nxt.tmr = s_r.sp[epcs_pkg::SP_COOL];
                end
            end
            epcs_pkg::ST_COOL: begin
                if (s_r.tmr == 16'h0) begin
                    s_nxt.st = epcs_pkg::ST_IDLE;
                end
            end
            epcs_pkg::ST_SHUT: begin
                if (clr) begin
                    s_nxt.st = epcs_pkg::ST_IDLE;
                end
            end
            default: s_nxt.st = epcs_pkg::ST_IDLE;
        endcase
        // a trip in the clearing cycle wins over the clear
        s_nxt.oil_sd = (s_r.oil_sd & ~clr) | oil_trip;
        s_nxt.temp_sd = (s_r.temp_sd & ~clr) | temp_trip;
        s_nxt.fuel_sd = (s_r.fuel_sd & ~clr) | fuel_trip;
        s_nxt.fail_sd = (s_r.fail_sd & ~clr) | fail_trip;
        if (oil_trip | temp_trip | fuel_trip | fail_trip) begin
            s_nxt.st = epcs_pkg::ST_SHUT;
        end
        s_nxt.fuel_al = (s_r.sp[epcs_pkg::SP_FUEL_AL] != 16'h0)
            && (fuel_level <= s_r.sp[epcs_pkg::SP_FUEL_AL]);
        if (battery_volts < s_r.sp[epcs_pkg::SP_BATT]) begin
            s_nxt.batt_al = 1'b1;
        end else if (battery_volts >= 16'(s_r.sp[epcs_pkg::SP_BATT]
                + epcs_pkg::BATT_HYST)) begin
            s_nxt.batt_al = 1'b0;
        end
        // speed target per phase
        case (s_r.st)
            epcs_pkg::ST_WARM: tgt = s_r.ctrl[epcs_pkg::C_AUTO]
                ? s_r.sp[epcs_pkg::SP_WARM_SPD] : s_r.load;
            epcs_pkg::ST_COOL: tgt = s_r.sp[epcs_pkg::SP_COOL_SPD];
            epcs_pkg::ST_LOAD: tgt = s_r.load;
            default: tgt = 16'h0;
        endcase
        if (rate_tick && s_r.cmd < tgt) begin
            diff = tgt - s_r.cmd;
            s_nxt.cmd = s_r.cmd + ((diff < s_r.sp[epcs_pkg::SP_RISE])
                ? diff : s_r.sp[epcs_pkg::SP_RISE]);
        end else if (rate_tick && s_r.cmd > tgt) begin
            diff = s_r.cmd - tgt;
            s_nxt.cmd = s_r.cmd - ((diff < s_r.sp[epcs_pkg::SP_FALL])
                ? diff : s_r.sp[epcs_pkg::SP_FALL]);
        end
        // the clamp overrides the ramp while loaded
        if (s_r.st == epcs_pkg::ST_LOAD) begin
            if (s_nxt.cmd < s_r.sp[epcs_pkg::SP_FLOOR]) begin
                s_nxt.cmd = s_r.sp[epcs_pkg::SP_FLOOR];
            end
            if (s_nxt.cmd > s_r.sp[epcs_pkg::SP_CEIL]) begin
                s_nxt.cmd = s_r.sp[epcs_pkg::SP_CEIL];
            end
        end
        if (!eng_on) begin
            s_nxt.cmd = 16'h0;
        end
        // a started pulse always runs out, which damps hunting
        if (s_r.thr_cnt != 16'h0) begin
            if (us_tick) begin
                s_nxt.thr_cnt = s_r.thr_cnt - 16'h1;
            end
        end else begin
            want_up = s_r.ctrl[epcs_pkg::C_MECH] && eng_on
                && (s_r.rpm < s_r.cmd);
            want_dn = s_r.ctrl[epcs_pkg::C_MECH] && eng_on
                && (s_r.rpm > s_r.cmd);
            s_nxt.up = want_up;
            s_nxt.dn = want_dn;
            s_nxt.thr_cnt = (want_up | want_dn)
                ? s_r.sp[epcs_pkg::SP_PULSE] : 16'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl <= epcs_pkg::CTRL_RST;
            s_r.load <= epcs_pkg::LOAD_RST;
            for (int i = 0; i < epcs_pkg::SP_N; i++) begin
                s_r.sp[i] <= epcs_pkg::SP_RST[i];
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign starter = s_r.st == epcs_pkg::ST_CRANK;
    assign fuel_run = (s_r.st == epcs_pkg::ST_CRANK) || eng_on;
    assign clutch = s_r.st == epcs_pkg::ST_LOAD;
    assign throttle_up = s_r.up;
    assign throttle_down = s_r.dn;
    assign shutdown = any_sd;
    assign alarm = s_r.fuel_al | s_r.batt_al;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_oil_idle_trip: assert property (
        eng_on && lock_done && s_r.rpm >= s_r.sp[epcs_pkg::SP_REF_LO]
        && s_r.rpm < s_r.sp[epcs_pkg::SP_REF_HI]
        && oil_press <= s_r.sp[epcs_pkg::SP_OIL_LO]
        |=> s_r.oil_sd && s_r.st == epcs_pkg::ST_SHUT)
        else $error("idle oil trip missed");
    chk_oil_run_trip: assert property (
        eng_on && lock_done && s_r.rpm >= s_r.sp[epcs_pkg::SP_REF_HI]
        && s_r.rpm >= s_r.sp[epcs_pkg::SP_REF_LO]
        && oil_press <= s_r.sp[epcs_pkg::SP_OIL_HI]
        |=> s_r.oil_sd)
        else $error("run oil trip missed");
    chk_oil_lockout: assert property (
        !s_r.oil_sd && !lock_done |=> !s_r.oil_sd)
        else $error("oil trip during lockout");
    chk_temp_trip: assert property (
        coolant_temp > s_r.sp[epcs_pkg::SP_TEMP] |=> s_r.temp_sd ##1 shutdown)
        else $error("coolant trip missed");
    chk_fuel_alarm_off: assert property (
        s_r.sp[epcs_pkg::SP_FUEL_AL] == 16'h0 |=> !s_r.fuel_al)
        else $error("fuel alarm while disabled");
    chk_fuel_trip: assert property (
        s_r.sp[epcs_pkg::SP_FUEL_SD] != 16'h0
        && fuel_level <= s_r.sp[epcs_pkg::SP_FUEL_SD] |=> s_r.fuel_sd)
        else $error("fuel shutdown missed");
    chk_batt_hold: assert property (
        s_r.batt_al && battery_volts < 16'(s_r.sp[epcs_pkg::SP_BATT]
        + epcs_pkg::BATT_HYST) |=> s_r.batt_al)
        else $error("battery alarm cleared early");
    chk_latch_hold: assert property (
        s_r.oil_sd && !clr |=> s_r.oil_sd && shutdown)
        else $error("oil shutdown not held");
    chk_attempt_limit: assert property (
        s_r.st == epcs_pkg::ST_CRANK && !running && s_r.tmr == 16'h0
        && s_r.tries >= s_r.sp[epcs_pkg::SP_TRIES][7:0]
        |=> s_r.fail_sd && s_r.st == epcs_pkg::ST_SHUT && !starter)
        else $error("start failure missed");
    chk_starter_release: assert property (
        starter && running |=> !starter)
        else $error("starter not released");
    chk_load_bounds: assert property (
        s_r.st == epcs_pkg::ST_LOAD && $past(s_r.st) == epcs_pkg::ST_LOAD
        && !$past(wr)
        |-> s_r.cmd >= s_r.sp[epcs_pkg::SP_FLOOR]
        && s_r.cmd <= s_r.sp[epcs_pkg::SP_CEIL])
        else $error("loaded speed out of bounds");
    chk_pulse_floor: assert property (
        s_r.up && s_r.thr_cnt != 16'h0 |=> s_r.up)
        else $error("throttle pulse cut short");

    cov_reach_load: cover property (
        s_r.st == epcs_pkg::ST_WARM ##1 s_r.st == epcs_pkg::ST_LOAD);
    cov_rest: cover property (
        s_r.st == epcs_pkg::ST_CRANK ##1 s_r.st == epcs_pkg::ST_REST);
    cov_false_start: cover property (s_r.st == epcs_pkg::ST_WAIT);
    cov_fail: cover property ($rose(s_r.fail_sd));
endmodule

// ### verification/epcs_engine.sv
// Purpose: far-side engine, fires only when allowed
// Assumes: starter plus fuel start it, fuel loss stops it
// Notes: pulse line rests low while stopped
`timescale 1ns/1ns
module epcs_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic starter,
    input wire logic fuel_run,
    input wire logic fires_ok,
    output logic speed_pulse
);
    logic run_r;
    // one pulse every two cycles, so a window of 50 reads 25 rpm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            speed_pulse <= 1'b0;
        end else begin
            run_r <= fuel_run && fires_ok && (run_r || starter);
            speed_pulse <= run_r && !speed_pulse;
        end
    end
endmodule

// ### verification/epcs_top_tb.sv
// Purpose: self-checking bench for epcs_top
// Assumes: 100-cycle second tick, engine model on far side
// Notes: speed levels rewritten low to suit the short window
`timescale 1ns/1ns
module epcs_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, seed;
    logic [15:0] oil, temp, fuel, batt;
    logic spd, starter, fuel_run, clutch, shutdown, alarm, fires;
    logic thr_up, thr_dn;
    logic [3:0] bv;
    int err_count, total_checks, n;
    epcs_top #(.SEC_CYCLES(100), .RATE_CYCLES(10)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oil_press(oil), .coolant_temp(temp),
        .fuel_level(fuel), .battery_volts(batt), .speed_pulse(spd),
        .starter(starter), .fuel_run(fuel_run), .clutch(clutch),
        .throttle_up(thr_up), .throttle_down(thr_dn),
        .shutdown(shutdown), .alarm(alarm));
    epcs_engine eng (.pclk(pclk), .presetn(presetn), .starter(starter),
        .fuel_run(fuel_run), .fires_ok(fires), .speed_pulse(spd));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic fuel_exp(input logic [15:0] f, sp);
        return (sp != 16'h0000) && (f <= sp);
    endfunction
    task end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, g);
        total_checks++;
        if (g !== x) begin
            $display("BAD %s exp %h got %h", nm, x, g);
            err_count++;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_count++;
            end_sim;
        end
    endtask
    task sp(input int i, input logic [15:0] v);
        apb(1'b1, 8'(8'h40 + 4 * i), {16'h0000, v});
    endtask
    // wait on starter, clutch or shutdown, settled at falling edge
    task wait_on(input int s, input logic v, input int lim);
        n = 0;
        while ((s == 0 ? starter : s == 1 ? clutch : shutdown) !== v
               && n < lim) begin
            @(negedge pclk);
            n++;
        end
        chk("wait bound", 32'h1, {31'h0, n < lim});
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        err_count++;
        end_sim;
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fires} = '0;
        {oil, temp, fuel, batt} = {16'h0064, 16'h0064, 16'h0000, 16'h0078};
        seed = 32'h5860C7AF;
        err_count = 0;
        total_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < epcs_pkg::SP_N; i++) begin
            apb(1'b0, 8'(8'h40 + 4 * i), 32'h0);
            chk("setpoint", {16'h0, epcs_pkg::SP_RST[i]}, q);
        end
        apb(1'b0, epcs_pkg::A_CTRL, 32'h0);
        chk("ctrl", {29'h0, epcs_pkg::CTRL_RST}, q);
        apb(1'b0, 8'hA0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        chk("fuel off", 32'h0, {31'h0, alarm});
        chk("fuel sd off", 32'h0, {31'h0, shutdown});
        sp(epcs_pkg::SP_CRANK_STOP, 16'h0014);
        sp(epcs_pkg::SP_REF_LO, 16'h000A);
        sp(epcs_pkg::SP_REF_HI, 16'h03E8);
        sp(epcs_pkg::SP_TRIES, 16'h0002);
        sp(epcs_pkg::SP_CRANK, 16'h0002);
        sp(epcs_pkg::SP_REST, 16'h0002);
        sp(epcs_pkg::SP_WARM, 16'h0003);
        sp(epcs_pkg::SP_LOCK, 16'h0001);
        apb(1'b1, epcs_pkg::A_CTRL, 32'h7);
        wait_on(0, 1'b1, 20);
        wait_on(0, 1'b0, 300);
        chk("crank len", 32'h1, {31'h0, n >= 99 && n <= 202});
        wait_on(0, 1'b1, 300);
        chk("rest len", 32'h1, {31'h0, n >= 99 && n <= 202});
        wait_on(2, 1'b1, 300);
        apb(1'b0, epcs_pkg::A_STAT, 32'h0);
        chk("start fail", 32'h1, {31'h0, q[6]});
        apb(1'b1, epcs_pkg::A_CTRL, 32'hE);
        wait_on(2, 1'b0, 5);
        // longer crank so only speed can end it
        sp(epcs_pkg::SP_CRANK, 16'h0003);
        fires <= 1'b1;
        apb(1'b1, epcs_pkg::A_CTRL, 32'h7);
        wait_on(0, 1'b1, 20);
        wait_on(0, 1'b0, 150);
        apb(1'b0, epcs_pkg::A_STAT, 32'h0);
        chk("warm state", {29'h0, epcs_pkg::ST_WARM}, {29'h0, q[2:0]});
        wait_on(1, 1'b1, 400);
        chk("warm len", 32'h1, {31'h0, n >= 190});
        repeat (120) @(posedge pclk);
        apb(1'b0, epcs_pkg::A_CMD, 32'h0);
        chk("cmd bounds", 32'h1,
            {31'h0, q >= 32'h02EE && q <= 32'h0640});
        chk("pulse held", 32'h1, {31'h0, thr_up ^ thr_dn});
        oil <= 16'h0010;
        repeat (4) @(negedge pclk);
        chk("oil above idle", 32'h0, {31'h0, shutdown});
        @(posedge pclk);
        oil <= 16'h000F;
        wait_on(2, 1'b1, 10);
        @(posedge pclk);
        oil <= 16'h0064;
        // two dead windows so the restart reads zero speed
        repeat (120) @(negedge pclk);
        chk("oil latch", 32'h3, {30'h0, shutdown, !fuel_run});
        apb(1'b1, epcs_pkg::A_CTRL, 32'hF);
        wait_on(0, 1'b1, 20);
        wait_on(0, 1'b0, 200);
        sp(epcs_pkg::SP_REF_HI, 16'h0014);
        repeat (120) @(posedge pclk);
        oil <= 16'h0010;
        wait_on(2, 1'b1, 10);
        @(posedge pclk);
        oil <= 16'h0064;
        apb(1'b1, epcs_pkg::A_CTRL, 32'hE);
        temp <= 16'h00DC;
        repeat (4) @(negedge pclk);
        chk("temp at level", 32'h0, {31'h0, shutdown});
        @(posedge pclk);
        temp <= 16'h00DD;
        wait_on(2, 1'b1, 5);
        @(posedge pclk);
        temp <= 16'h0064;
        apb(1'b1, epcs_pkg::A_CTRL, 32'hE);
        sp(epcs_pkg::SP_FUEL_AL, 16'h0014);
        repeat (16) begin
            seed = xs(seed);
            @(posedge pclk);
            fuel <= {11'h0, seed[4:0]};
            repeat (4) @(negedge pclk);
            chk("fuel alarm", {31'h0, fuel_exp(fuel, 16'h0014)},
                {31'h0, alarm});
        end
        @(posedge pclk);
        fuel <= 16'h0032;
        bv = 4'b1100;
        foreach (bv[i]) begin
            @(posedge pclk);
            batt <= i == 3 ? 16'h0063 : i == 1 ? 16'h0066 : 16'h0065;
            repeat (4) @(negedge pclk);
            chk("battery", {31'h0, bv[i]}, {31'h0, alarm});
        end
        sp(epcs_pkg::SP_FUEL_SD, 16'h000A);
        fuel <= 16'h000A;
        wait_on(2, 1'b1, 5);
        apb(1'b0, epcs_pkg::A_STAT, 32'h0);
        chk("fuel sd", 32'h1, {31'h0, q[5]});
        end_sim;
    end
endmodule
